/* File: design/vss_regs.svh */
// Constants for the vector segment sequencer: buffer size, scaling, fixed-point layout.
// Assumes inclusion by bare name from the package and the design file.
`ifndef VSS_REGS_SVH
`define VSS_REGS_SVH
`define VSS_SLOTS 31
`define VSS_CNT_W 5
`define VSS_RATIO_ONE 17'h0_2710
`define VSS_RATIO_MAX 17'h1_86A0
`define VSS_FRAC 16
`define VSS_ARC_MUL 32'h0000_00C9
`define VSS_ARC_SHIFT 11
`define VSS_COS_SHIFT 8
`define VSS_CREEP 32'h0000_0100
`endif

/* File: design/vss_pkg.sv */
// Types shared by the sequencer: commands, segments, state and trippoint kinds.
// Assumes vss_regs.svh is on the include path.
`include "vss_regs.svh"
package vss_pkg;
	typedef enum logic [3:0] {
		LINE_SEGMENT_CMD, ARC_SEGMENT_CMD, SEQUENCE_END_CMD, BEGIN_SEQUENCE_CMD,
		CLEAR_SEQUENCE_CMD, SEQUENCE_STOP_CMD, ABORT_MOTION_CMD, SET_VECTOR_SPEED,
		SET_VECTOR_ACCELERATION, SET_VECTOR_DECELERATION, SET_FEED_RATE_RATIO,
		AFTER_VECTOR_TRIPPOINT, AFTER_SEQUENCE_TRIPPOINT
	} op_t;
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUNNING, SEQ_STOPPING} seq_state_t;
	typedef enum logic [1:0] {NO_TRIP, VECTOR_TRIP, SEQUENCE_TRIP} trip_t;
	typedef struct packed {
		logic isArc;
		logic signed [31:0] distance;
		logic [5:0] startAngle;
		logic signed [10:0] sweep;
		logic hasEntry;
		logic [31:0] entrySpeed;
		logic hasExit;
		logic [31:0] exitSpeed;
	} seg_t;
	typedef struct packed {
		op_t op;
		seg_t seg;
		logic [31:0] value;
	} cmd_t;
endpackage

/* File: design/vector_segment_sequencer.sv */
// Single-axis coordinated sequencer: segment buffer, speed planner and path stepper.
// Assumes one 20 MHz clock, synchronous active-low reset and a host on the command port.
// Notes on behaviour
// (RULE1) Segments are lines or arcs; a sequence is closed by a sequence-end command.
// (RULE2) At sequence begin the present position becomes local zero for that sequence.
// (RULE3) Line segments give an end point relative to the segment's start.
// (RULE4) Arcs use radius, start angle, swept angle; zero is +x, CCW positive.
// (RULE5) At most 31 segments held; host closes with sequence-end.
// (RULE6) Begin starts motion; segments keep being accepted while moving.
// (RULE7) Clear discards buffered segments before motion starts.
// (RULE8) Stop ramps down at programmed deceleration; abort halts at once.
// (RULE9) After sequence-end, decelerate to rest at the end of the last segment.
// (RULE10) Buffer empty without sequence-end: halt instantly, no ramp.
// (RULE11) Free slot count: 31 means empty, 0 means full and refusing.
// (RULE12) Segment counter shows executing segment index, zero at first.
// (RULE13) Entry speed acts as a speed setting at segment start.
// (RULE14) Exit speed is reached at segment end, braking planned from deceleration.
// (RULE15) Only one exit-speed constraint is tracked at a time.
// (RULE16) Feed ratio 0..10 in steps of .0001 scales speed, not acceleration.
// (RULE17) After-vector trippoint holds commands until relative path distance is done.
// (RULE18) After-sequence trippoint holds commands until the sequence completes.
// (RULE19) Last junction coordinate gives absolute axis position at latest junction.
// (RULE20) Path distance travelled reports distance along the running sequence.
// (RULE21) Sequence path length reports total path length of queued segments.
// (RULE22) Speed, acceleration and deceleration are settings; speed acts immediately.
// (RULE23) Segments run in arrival order, each freeing a slot when taken.
`include "vss_regs.svh"

module seg_fifo #(
	parameter int WIDTH = $bits(vss_pkg::seg_t),
	parameter int DEPTH = `VSS_SLOTS
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic flush,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData,
	output logic [$clog2(DEPTH+1)-1:0] freeCount
);
	localparam int IW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [IW-1:0] wrIdx, rdIdx, next_wrIdx, next_rdIdx;
	logic [CW-1:0] count, next_count, next_freeCount;
	logic push, pop;

	function automatic logic [IW-1:0] wrap(input logic [IW-1:0] i);
		wrap = (i == IW'(DEPTH - 1)) ? '0 : IW'(i + 1'b1);
	endfunction

	assign inReady = count != CW'(DEPTH);
	assign outValid = count != '0;
	assign outData = mem[rdIdx];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always_comb begin
		next_wrIdx = push ? wrap(wrIdx) : wrIdx;
		next_rdIdx = pop ? wrap(rdIdx) : rdIdx;
		next_count = CW'(count + CW'(push) - CW'(pop));
		if (flush) begin
			next_wrIdx = '0;
			next_rdIdx = '0;
			next_count = '0;
		end
		next_freeCount = CW'(CW'(DEPTH) - next_count);
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wrIdx <= '0;
			rdIdx <= '0;
			count <= '0;
			freeCount <= CW'(DEPTH);
		end else begin
			wrIdx <= next_wrIdx;
			rdIdx <= next_rdIdx;
			count <= next_count;
			freeCount <= next_freeCount;
		end
	end

	// Storage is write-only on push; a flush just resets the pointers
	always_ff @(posedge core_clk) begin
		if (push && !flush) begin
			mem[wrIdx] <= inData;
		end
	end
endmodule

module vector_segment_sequencer (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic cmdValid,
	output logic cmdReady,
	output logic segmentReady,
	input wire vss_pkg::cmd_t cmd,
	input wire logic vectorModeEnable,
	output logic running,
	output logic bufferStarved,
	output logic signed [31:0] axisPosition,
	output logic signed [31:0] localPosition,
	output logic [31:0] vectorVelocity,
	output logic [`VSS_CNT_W-1:0] freeSlotCount,
	output logic [15:0] segmentCounter,
	output logic signed [31:0] lastJunctionCoordinate,
	output logic [31:0] pathDistanceTravelled,
	output logic [31:0] sequencePathLength
);
	vss_pkg::seq_state_t state, next_state;
	vss_pkg::trip_t tripKind, next_tripKind;
	vss_pkg::seg_t cur, next_cur, fifoOut;
	logic haveSeg, next_haveSeg, endSeen, next_endSeen, next_running, next_bufferStarved;
	logic next_cmdReady, next_segmentReady;
	logic [47:0] segTravel, next_segTravel, arcAcc, next_arcAcc, pathTravel, next_pathTravel;
	logic [47:0] stepTravel, stepAcc;
	logic [5:0] arcAngle, next_arcAngle;
	logic [10:0] stepsLeft, next_stepsLeft;
	logic [31:0] stepLen, next_stepLen, curLen, next_curLen, tripTarget, next_tripTarget;
	logic [31:0] vectorSpeed, next_vectorSpeed, accelRate, next_accelRate;
	logic [31:0] decelRate, next_decelRate, next_velocity, next_seqLen;
	logic [31:0] scaled, target, limitSpeed, remain;
	logic [16:0] feedRatio, next_feedRatio;
	logic signed [31:0] origin, next_origin, junctionPos, next_junctionPos;
	logic signed [31:0] next_axis, next_local, next_lastJunction;
	logic signed [47:0] arcProd;
	logic [15:0] next_segCount;
	logic [63:0] vv, mm;
	logic [80:0] need;
	logic [48:0] prod;
	logic accept, isSegCmd, pushSeg, popSeg, flushFifo, fifoInReady, fifoOutValid;
	logic segDone, abortNow, brake, limitActive, lastSeg;

	assign pathDistanceTravelled = pathTravel[47:`VSS_FRAC];

	seg_fifo #(.WIDTH($bits(vss_pkg::seg_t)), .DEPTH(`VSS_SLOTS)) segBuffer (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.flush(flushFifo),
		.inValid(pushSeg),
		.inReady(fifoInReady),
		.inData(cmd.seg),
		.outValid(fifoOutValid),
		.outReady(popSeg),
		.outData(fifoOut),
		.freeCount(freeSlotCount)
	);

	// Length of one angle step (1/64 turn) of an arc, never zero
	function automatic logic [31:0] arcStep(input logic signed [31:0] r);
		logic [63:0] p;
		p = 64'($unsigned(r)) * 64'(`VSS_ARC_MUL);
		arcStep = (p[`VSS_ARC_SHIFT +: 32] == '0) ? 32'h0000_0001 : p[`VSS_ARC_SHIFT +: 32];
	endfunction

	function automatic logic [10:0] sweepMag(input vss_pkg::seg_t s);
		sweepMag = s.sweep[10] ? 11'(-s.sweep) : 11'(s.sweep);
	endfunction

	function automatic logic [31:0] segLength(input vss_pkg::seg_t s);
		if (s.isArc) begin
			segLength = 32'(arcStep(s.distance) * sweepMag(s));
		end else begin
			segLength = s.distance[31] ? 32'(-s.distance) : 32'(s.distance);
		end
	endfunction

	// Quarter-wave cosine in Q8, 16 steps per quadrant
	function automatic logic signed [15:0] quarterCos(input logic [4:0] k);
		case (k)
			5'h00: quarterCos = 16'h0100;
			5'h01: quarterCos = 16'h00FF;
			5'h02: quarterCos = 16'h00FB;
			5'h03: quarterCos = 16'h00F5;
			5'h04: quarterCos = 16'h00ED;
			5'h05: quarterCos = 16'h00E2;
			5'h06: quarterCos = 16'h00D5;
			5'h07: quarterCos = 16'h00C6;
			5'h08: quarterCos = 16'h00B5;
			5'h09: quarterCos = 16'h00A2;
			5'h0A: quarterCos = 16'h008E;
			5'h0B: quarterCos = 16'h0079;
			5'h0C: quarterCos = 16'h0062;
			5'h0D: quarterCos = 16'h004A;
			5'h0E: quarterCos = 16'h0032;
			5'h0F: quarterCos = 16'h0019;
			default: quarterCos = 16'h0000;
		endcase
	endfunction

	// Angle zero lies on +x and angles grow counter-clockwise
	function automatic logic signed [15:0] cosOf(input logic [5:0] a);
		logic [4:0] idx, mirror;
		idx = {1'b0, a[3:0]};
		mirror = 5'(5'h10 - idx);
		case (a[5:4])
			2'h0: cosOf = quarterCos(idx);
			2'h1: cosOf = 16'(-quarterCos(mirror));
			2'h2: cosOf = 16'(-quarterCos(idx));
			default: cosOf = quarterCos(mirror);
		endcase
	endfunction

	always_comb begin
		next_state = state;
		next_tripKind = tripKind;
		next_tripTarget = tripTarget;
		next_cur = cur;
		next_haveSeg = haveSeg;
		next_endSeen = endSeen;
		next_bufferStarved = bufferStarved;
		next_segTravel = segTravel;
		next_arcAcc = arcAcc;
		next_pathTravel = pathTravel;
		next_arcAngle = arcAngle;
		next_stepsLeft = stepsLeft;
		next_stepLen = stepLen;
		next_curLen = curLen;
		next_vectorSpeed = vectorSpeed;
		next_accelRate = accelRate;
		next_decelRate = decelRate;
		next_feedRatio = feedRatio;
		next_velocity = vectorVelocity;
		next_seqLen = sequencePathLength;
		next_origin = origin;
		next_junctionPos = junctionPos;
		next_axis = axisPosition;
		next_lastJunction = lastJunctionCoordinate;
		next_segCount = segmentCounter;
		popSeg = 1'b0;
		flushFifo = 1'b0;
		segDone = 1'b0;
		abortNow = 1'b0;
		arcProd = '0;
		accept = cmdValid && cmdReady;
		isSegCmd = cmd.op == vss_pkg::LINE_SEGMENT_CMD || cmd.op == vss_pkg::ARC_SEGMENT_CMD;
		// Buffer fills while moving, too
		pushSeg = accept && isSegCmd && segmentReady && vectorModeEnable && fifoInReady; // RULE6

		if (tripKind == vss_pkg::VECTOR_TRIP
				&& (pathTravel[47:`VSS_FRAC] >= tripTarget || state == vss_pkg::SEQ_IDLE)) begin
			next_tripKind = vss_pkg::NO_TRIP; // RULE17
		end
		if (tripKind == vss_pkg::SEQUENCE_TRIP && state == vss_pkg::SEQ_IDLE) begin
			next_tripKind = vss_pkg::NO_TRIP; // RULE18
		end

		if (accept) begin
			case (cmd.op)
				vss_pkg::SEQUENCE_END_CMD: next_endSeen = 1'b1; // RULE1
				vss_pkg::BEGIN_SEQUENCE_CMD: begin
					if (state == vss_pkg::SEQ_IDLE) begin
						next_state = vss_pkg::SEQ_RUNNING; // RULE6
						next_origin = axisPosition; // RULE2
						next_junctionPos = axisPosition;
						next_lastJunction = axisPosition;
						next_pathTravel = '0;
						next_segCount = '0; // RULE12
						next_haveSeg = 1'b0;
						next_bufferStarved = 1'b0;
					end
				end
				vss_pkg::CLEAR_SEQUENCE_CMD: begin
					if (state == vss_pkg::SEQ_IDLE) begin
						flushFifo = 1'b1; // RULE7
						next_seqLen = '0;
						next_endSeen = 1'b0;
					end
				end
				vss_pkg::SEQUENCE_STOP_CMD: begin
					if (state != vss_pkg::SEQ_IDLE) begin
						next_state = vss_pkg::SEQ_STOPPING; // RULE8
					end
				end
				vss_pkg::ABORT_MOTION_CMD: abortNow = 1'b1;
				vss_pkg::SET_VECTOR_SPEED: next_vectorSpeed = cmd.value; // RULE22
				vss_pkg::SET_VECTOR_ACCELERATION: next_accelRate = cmd.value; // RULE22
				vss_pkg::SET_VECTOR_DECELERATION: next_decelRate = cmd.value; // RULE22
				vss_pkg::SET_FEED_RATE_RATIO: begin
					next_feedRatio = (cmd.value > 32'(`VSS_RATIO_MAX)) ? `VSS_RATIO_MAX
						: cmd.value[16:0]; // RULE16
				end
				vss_pkg::AFTER_VECTOR_TRIPPOINT: begin
					next_tripKind = vss_pkg::VECTOR_TRIP; // RULE17
					next_tripTarget = 32'(pathTravel[47:`VSS_FRAC] + cmd.value);
				end
				vss_pkg::AFTER_SEQUENCE_TRIPPOINT: next_tripKind = vss_pkg::SEQUENCE_TRIP; // RULE18
				default: ;
			endcase
		end
		if (pushSeg) begin
			next_seqLen = 32'(sequencePathLength + segLength(cmd.seg)); // RULE21
		end

		// Speed planning: ratio scales speed only, rates stay as set
		prod = 49'(vectorSpeed * feedRatio);
		scaled = 32'(prod / 49'(`VSS_RATIO_ONE)); // RULE16
		lastSeg = endSeen && !fifoOutValid;
		// One exit constraint at a time: the current segment's, or the final stop
		limitActive = haveSeg && (lastSeg || cur.hasExit); // RULE15
		limitSpeed = lastSeg ? 32'h0000_0000 : cur.exitSpeed; // RULE9
		remain = cur.isArc ? 32'(stepsLeft * stepLen)
			: 32'(curLen - pathTravel[47:`VSS_FRAC] + pathTravel[47:`VSS_FRAC]
				- segTravel[47:`VSS_FRAC]);
		vv = 64'(vectorVelocity * vectorVelocity);
		mm = 64'(limitSpeed * limitSpeed);
		need = 81'(decelRate * remain) << (`VSS_FRAC + 1);
		// Braking starts once v^2 - m^2 covers 2*decel*remaining distance
		brake = limitActive && vv > mm && 81'(vv - mm) >= need; // RULE14
		target = scaled;
		if (state == vss_pkg::SEQ_STOPPING) begin
			target = '0;
		end else if (brake) begin
			target = (limitSpeed < scaled) ? limitSpeed : scaled;
			// Creep keeps the segment end reachable when braking to rest
			if (target < `VSS_CREEP) target = `VSS_CREEP;
		end
		if (state != vss_pkg::SEQ_IDLE) begin
			if (vectorVelocity < target) begin
				next_velocity = (target - vectorVelocity > accelRate)
					? 32'(vectorVelocity + accelRate) : target;
			end else begin
				next_velocity = (vectorVelocity - target > decelRate)
					? 32'(vectorVelocity - decelRate) : target; // RULE8
			end
		end

		stepTravel = 48'(segTravel + 48'(vectorVelocity));
		stepAcc = 48'(arcAcc + 48'(vectorVelocity));
		if (state != vss_pkg::SEQ_IDLE) begin
			if (!haveSeg) begin
				segDone = 1'b1;
			end else begin
				next_pathTravel = 48'(pathTravel + 48'(vectorVelocity)); // RULE20
				if (!cur.isArc) begin
					next_segTravel = stepTravel;
					if (stepTravel[47:`VSS_FRAC] >= curLen) begin
						segDone = 1'b1;
						next_axis = 32'(junctionPos + cur.distance); // RULE3
					end else begin
						next_axis = cur.distance[31] ? 32'(junctionPos - stepTravel[47:`VSS_FRAC])
							: 32'(junctionPos + stepTravel[47:`VSS_FRAC]); // RULE3
					end
				end else if (stepsLeft == '0) begin
					segDone = 1'b1;
				end else begin
					next_arcAcc = stepAcc;
					if (stepAcc[47:`VSS_FRAC] >= stepLen) begin
						// One angle step per cycle; speeds above one step per cycle lag
						next_arcAcc = 48'(stepAcc - {stepLen, 16'h0000});
						next_arcAngle = cur.sweep[10] ? 6'(arcAngle - 1'b1) : 6'(arcAngle + 1'b1);
						next_stepsLeft = 11'(stepsLeft - 1'b1);
						arcProd = 48'(cur.distance * 16'(cosOf(next_arcAngle)
							- cosOf(cur.startAngle))); // RULE4
						next_axis = 32'(junctionPos + 32'(arcProd >>> `VSS_COS_SHIFT));
						segDone = stepsLeft == 11'h001;
					end
				end
			end
			if (segDone) begin
				if (fifoOutValid) begin
					popSeg = 1'b1; // RULE23
					next_cur = fifoOut;
					next_curLen = segLength(fifoOut);
					next_haveSeg = 1'b1;
					next_segTravel = '0;
					next_arcAcc = '0;
					next_arcAngle = fifoOut.startAngle;
					next_stepsLeft = sweepMag(fifoOut);
					next_stepLen = arcStep(fifoOut.distance);
					next_junctionPos = next_axis;
					next_lastJunction = next_axis; // RULE19
					if (haveSeg) next_segCount = 16'(segmentCounter + 1'b1); // RULE12
					if (fifoOut.hasEntry) next_vectorSpeed = fifoOut.entrySpeed; // RULE13
				end else if (endSeen || state == vss_pkg::SEQ_STOPPING) begin
					next_state = vss_pkg::SEQ_IDLE; // RULE9
					next_velocity = '0;
					next_haveSeg = 1'b0;
					next_endSeen = 1'b0;
					next_lastJunction = next_axis;
				end else begin
					next_state = vss_pkg::SEQ_IDLE; // RULE10
					next_velocity = '0;
					next_haveSeg = 1'b0;
					next_bufferStarved = 1'b1;
				end
			end
			if (state == vss_pkg::SEQ_STOPPING && next_velocity == '0) begin
				next_state = vss_pkg::SEQ_IDLE; // RULE8
				next_haveSeg = 1'b0;
				next_endSeen = 1'b0;
				flushFifo = 1'b1;
			end
		end
		if (abortNow) begin
			next_state = vss_pkg::SEQ_IDLE; // RULE8
			next_velocity = '0;
			next_haveSeg = 1'b0;
			next_endSeen = 1'b0;
			flushFifo = 1'b1;
		end
		next_local = 32'(next_axis - next_origin); // RULE2
		next_running = next_state != vss_pkg::SEQ_IDLE;
		next_cmdReady = next_tripKind == vss_pkg::NO_TRIP;
		// Conservative: a slot freed this cycle is offered two cycles later
		next_segmentReady = freeSlotCount > `VSS_CNT_W'(1)
			|| (freeSlotCount == `VSS_CNT_W'(1) && !pushSeg); // RULE11
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state <= vss_pkg::SEQ_IDLE;
			tripKind <= vss_pkg::NO_TRIP;
			tripTarget <= '0;
			cur <= '0;
			haveSeg <= 1'b0;
			endSeen <= 1'b0;
			bufferStarved <= 1'b0;
			segTravel <= '0;
			arcAcc <= '0;
			pathTravel <= '0;
			arcAngle <= '0;
			stepsLeft <= '0;
			stepLen <= 32'h0000_0001;
			curLen <= '0;
			vectorSpeed <= '0;
			accelRate <= '0;
			decelRate <= '0;
			feedRatio <= `VSS_RATIO_ONE;
			vectorVelocity <= '0;
			sequencePathLength <= '0;
			origin <= '0;
			junctionPos <= '0;
			axisPosition <= '0;
			localPosition <= '0;
			lastJunctionCoordinate <= '0;
			segmentCounter <= '0;
			running <= 1'b0;
			cmdReady <= 1'b0;
			segmentReady <= 1'b0;
		end else begin
			state <= next_state;
			tripKind <= next_tripKind;
			tripTarget <= next_tripTarget;
			cur <= next_cur;
			haveSeg <= next_haveSeg;
			endSeen <= next_endSeen;
			bufferStarved <= next_bufferStarved;
			segTravel <= next_segTravel;
			arcAcc <= next_arcAcc;
			pathTravel <= next_pathTravel;
			arcAngle <= next_arcAngle;
			stepsLeft <= next_stepsLeft;
			stepLen <= next_stepLen;
			curLen <= next_curLen;
			vectorSpeed <= next_vectorSpeed;
			accelRate <= next_accelRate;
			decelRate <= next_decelRate;
			feedRatio <= next_feedRatio;
			vectorVelocity <= next_velocity;
			sequencePathLength <= next_seqLen;
			origin <= next_origin;
			junctionPos <= next_junctionPos;
			axisPosition <= next_axis;
			localPosition <= next_local;
			lastJunctionCoordinate <= next_lastJunction;
			segmentCounter <= next_segCount;
			running <= next_running;
			cmdReady <= next_cmdReady;
			segmentReady <= next_segmentReady;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_abortTaken;
		accept && cmd.op == vss_pkg::ABORT_MOTION_CMD;
	endsequence
	sequence s_beginTaken;
		accept && cmd.op == vss_pkg::BEGIN_SEQUENCE_CMD && state == vss_pkg::SEQ_IDLE;
	endsequence
	sequence s_starve;
		segDone && !fifoOutValid && !endSeen && state == vss_pkg::SEQ_RUNNING;
	endsequence

	property p_full_refuses;
		freeSlotCount == '0 |-> !segmentReady;
	endproperty
	a_full_refuses: assert property (p_full_refuses) else $error("segment offered while full"); // RULE11
	property p_abort_halts;
		s_abortTaken |=> vectorVelocity == '0 && !running && freeSlotCount == `VSS_CNT_W'(`VSS_SLOTS);
	endproperty
	a_abort_halts: assert property (p_abort_halts) else $error("abort did not halt"); // RULE8
	property p_begin_zero;
		s_beginTaken |=> localPosition == '0 && segmentCounter == '0 && running;
	endproperty
	a_begin_zero: assert property (p_begin_zero) else $error("begin did not zero"); // RULE2
	property p_counter_step;
		running && $past(running) && segmentCounter != $past(segmentCounter)
			|-> segmentCounter == 16'($past(segmentCounter) + 1'b1);
	endproperty
	a_counter_step: assert property (p_counter_step) else $error("counter skipped"); // RULE12
	property p_stop_ramps;
		state == vss_pkg::SEQ_STOPPING |=> vectorVelocity <= $past(vectorVelocity);
	endproperty
	a_stop_ramps: assert property (p_stop_ramps) else $error("speed rose while stopping"); // RULE8
	property p_seq_trip_holds;
		tripKind == vss_pkg::SEQUENCE_TRIP && running |=> !cmdReady;
	endproperty
	a_seq_trip_holds: assert property (p_seq_trip_holds) else $error("trip released early"); // RULE18
	property p_starve_halt;
		s_starve |=> vectorVelocity == '0 && bufferStarved && !running;
	endproperty
	a_starve_halt: assert property (p_starve_halt) else $error("starved without halt"); // RULE10
	property p_clear_empties;
		accept && cmd.op == vss_pkg::CLEAR_SEQUENCE_CMD && !running
			|=> freeSlotCount == `VSS_CNT_W'(`VSS_SLOTS) && sequencePathLength == '0;
	endproperty
	a_clear_empties: assert property (p_clear_empties) else $error("clear left segments"); // RULE7
	property p_pop_frees;
		popSeg && !pushSeg && !flushFifo |=> freeSlotCount == `VSS_CNT_W'($past(freeSlotCount) + 1'b1);
	endproperty
	a_pop_frees: assert property (p_pop_frees) else $error("pop did not free a slot"); // RULE23
	property p_junction;
		popSeg && haveSeg |=> lastJunctionCoordinate == axisPosition;
	endproperty
	a_junction: assert property (p_junction) else $error("junction not recorded"); // RULE19
endmodule

/* File: tb/vss_host_model.sv */
// Host model: offers one command at a time on the sequencer's command port.
// Assumes the bench calls send after reset and reads the command port's readiness.
module vss_host_model (
	input wire logic core_clk,
	input wire logic cmdReady,
	input wire logic segmentReady,
	output logic cmdValid,
	output vss_pkg::cmd_t cmd
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		cmdValid = 1'b0;
		cmd = '0;
	end
	// Holds the word until taken; segments also wait for buffer room
	task automatic send(input vss_pkg::op_t op, input logic [31:0] arg);
		vss_pkg::cmd_t c;
		logic ok;
		c = '0;
		c.op = op;
		c.seg.distance = arg;
		// Arcs: a quarter turn CCW from angle zero, entered at half speed
		c.seg.isArc = op == vss_pkg::ARC_SEGMENT_CMD;
		c.seg.sweep = 11'h010;
		c.seg.hasEntry = c.seg.isArc;
		c.seg.entrySpeed = 32'h0000_8000;
		c.value = arg;
		@(posedge core_clk);
		cmdValid <= 1'b1;
		cmd <= c;
		// Readiness is settled mid-cycle and holds until the edge that takes the word
		do begin
			@(negedge core_clk);
			ok = cmdReady && (segmentReady || op > vss_pkg::ARC_SEGMENT_CMD);
			@(posedge core_clk);
		end while (!ok);
		cmdValid <= 1'b0;
		// A released port shows no stale word
		cmd <= ~c;
	endtask
endmodule

/* File: tb/tb_vector_segment_sequencer.sv */
// Self-checking bench for the sequencer: buffer, sequence run, abort, starvation.
// Assumes the host model file and the design package are compiled first.
module tb_vector_segment_sequencer;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk, rst_n, cmdValid, cmdReady, segmentReady, running, bufferStarved;
	logic vectorModeEnable;
	vss_pkg::cmd_t cmd;
	logic signed [31:0] axisPosition, localPosition, lastJunctionCoordinate;
	logic [31:0] vectorVelocity, pathDistanceTravelled, sequencePathLength, sum, d;
	logic [4:0] freeSlotCount;
	logic [15:0] segmentCounter;
	int mismatches = 0, n_checks = 0, cycles = 0, n;
	vector_segment_sequencer vector_segment_sequencer_inst (.core_clk(core_clk), .rst_n(rst_n),
		.cmdValid(cmdValid), .cmdReady(cmdReady), .segmentReady(segmentReady), .cmd(cmd),
		.vectorModeEnable(vectorModeEnable), .running(running), .bufferStarved(bufferStarved),
		.axisPosition(axisPosition), .localPosition(localPosition),
		.vectorVelocity(vectorVelocity), .freeSlotCount(freeSlotCount),
		.segmentCounter(segmentCounter), .lastJunctionCoordinate(lastJunctionCoordinate),
		.pathDistanceTravelled(pathDistanceTravelled), .sequencePathLength(sequencePathLength));
	vss_host_model vss_host_model_inst (.core_clk(core_clk), .cmdReady(cmdReady),
		.segmentReady(segmentReady), .cmdValid(cmdValid), .cmd(cmd));
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks=%0d mismatches=%0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Pushes k random lines and returns their summed length
	task automatic push(input int k);
		sum = 32'h0000_0000;
		repeat (k) begin
			d = $urandom_range(60, 20);
			sum += d;
			vss_host_model_inst.send(vss_pkg::LINE_SEGMENT_CMD, d);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask
	// Ceiling well above the few hundred cycles the sequences need
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			end_of_test();
		end
	end
	initial begin
		rst_n = 1'b0;
		vectorModeEnable = 1'b1;
		void'($urandom(32'h85a3));
		tick(6);
		rst_n <= 1'b1;
		tick(2);
		chk(freeSlotCount, 32'h0000_001f);
		n = $urandom_range(10, 4);
		push(n);
		tick(1);
		chk(freeSlotCount, 31 - n);
		chk(sequencePathLength, sum);
		vss_host_model_inst.send(vss_pkg::CLEAR_SEQUENCE_CMD, 32'h0000_0000);
		tick(2);
		chk(freeSlotCount, 32'h0000_001f);
		push(31);
		tick(1);
		chk({freeSlotCount, segmentReady}, 32'h0000_0000);
		vss_host_model_inst.send(vss_pkg::CLEAR_SEQUENCE_CMD, 32'h0000_0000);
		vss_host_model_inst.send(vss_pkg::SET_VECTOR_SPEED, 32'h0001_0000);
		vss_host_model_inst.send(vss_pkg::SET_VECTOR_ACCELERATION, 32'h0001_0000);
		vss_host_model_inst.send(vss_pkg::SET_VECTOR_DECELERATION, 32'h0000_1000);
		push(3);
		vss_host_model_inst.send(vss_pkg::SEQUENCE_END_CMD, 32'h0000_0000);
		vss_host_model_inst.send(vss_pkg::BEGIN_SEQUENCE_CMD, 32'h0000_0000);
		tick(1);
		chk({15'h0000, running, segmentCounter}, 32'h0001_0000);
		chk(localPosition, 32'h0000_0000);
		vss_host_model_inst.send(vss_pkg::AFTER_SEQUENCE_TRIPPOINT, 32'h0000_0000);
		#1;
		chk(cmdReady, 32'h0000_0000);
		while (cmdReady !== 1'b1) tick(1);
		chk({bufferStarved, running}, 32'h0000_0000);
		chk(axisPosition, sum);
		chk(segmentCounter, 32'h0000_0002);
		chk(localPosition, sum);
		chk(pathDistanceTravelled, sum);
		chk(lastJunctionCoordinate, sum);
		// Half feed rate halves the programmed speed
		vss_host_model_inst.send(vss_pkg::SET_FEED_RATE_RATIO, 32'h0000_1388);
		push(3);
		vss_host_model_inst.send(vss_pkg::BEGIN_SEQUENCE_CMD, 32'h0000_0000);
		tick(1);
		chk(localPosition, 32'h0000_0000);
		tick(12);
		chk(vectorVelocity, 32'h0000_8000);
		vss_host_model_inst.send(vss_pkg::ABORT_MOTION_CMD, 32'h0000_0000);
		tick(1);
		chk(vectorVelocity, 32'h0000_0000);
		chk(running, 32'h0000_0000);
		chk(freeSlotCount, 32'h0000_001f);
		vss_host_model_inst.send(vss_pkg::SET_FEED_RATE_RATIO, 32'h0000_2710);
		push(1);
		vss_host_model_inst.send(vss_pkg::BEGIN_SEQUENCE_CMD, 32'h0000_0000);
		while (bufferStarved !== 1'b1) tick(1);
		chk(vectorVelocity, 32'h0000_0000);
		// Distance trippoint at one count per cycle, then a ramped stop
		push(3);
		vss_host_model_inst.send(vss_pkg::BEGIN_SEQUENCE_CMD, 32'h0000_0000);
		vss_host_model_inst.send(vss_pkg::AFTER_VECTOR_TRIPPOINT, 32'h0000_000a);
		do tick(1); while (cmdReady !== 1'b1);
		chk(pathDistanceTravelled, 32'h0000_000b);
		vss_host_model_inst.send(vss_pkg::SEQUENCE_STOP_CMD, 32'h0000_0000);
		tick(1);
		chk(vectorVelocity, 32'h0000_f000);
		while (running === 1'b1) tick(1);
		chk(vectorVelocity, 32'h0000_0000);
		chk(freeSlotCount, 32'h0000_001f);
		// A quarter turn from angle zero ends one radius back on the axis
		vss_host_model_inst.send(vss_pkg::ARC_SEGMENT_CMD, 32'h0000_0064);
		vss_host_model_inst.send(vss_pkg::SEQUENCE_END_CMD, 32'h0000_0000);
		vss_host_model_inst.send(vss_pkg::BEGIN_SEQUENCE_CMD, 32'h0000_0000);
		tick(20);
		chk(vectorVelocity, 32'h0000_8000);
		vss_host_model_inst.send(vss_pkg::AFTER_SEQUENCE_TRIPPOINT, 32'h0000_0000);
		do tick(1); while (cmdReady !== 1'b1);
		chk(localPosition, 32'hffff_ff9c);
		end_of_test();
	end
endmodule
